// *** common/hsl_pkg.sv ***
// shared constants and types for the hub status and link control register bank
package hsl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RELOAD  = 8'h01;
  localparam logic [7:0] IDX_STATUS  = 8'h04;
  localparam logic [7:0] IDX_THR_HI  = 8'h05;
  localparam logic [7:0] IDX_THR_LO  = 8'h06;
  localparam logic [7:0] IDX_WDOG    = 8'h07;
  localparam logic [7:0] IDX_I2C     = 8'h08;
  localparam logic [7:0] IDX_PAR_STS = 8'h0c;
  localparam logic [7:0] IDX_INT_STS = 8'h0d;
  localparam logic [7:0] IDX_INT_CLR = 8'h0e;
  localparam logic [7:0] IDX_INT_EN  = 8'h0f;
  // field positions
  localparam int BIT_RELOAD = 2;
  localparam int BIT_CKSUM  = 7;
  localparam int BIT_DONE   = 6;
  localparam int BIT_REFOK  = 4;
  localparam int INT_INIT   = 0;
  localparam int INT_REFLOS = 1;
  localparam int INT_WDOG   = 2;
  localparam int INT_PARITY = 3;
  localparam int INT_RBLOCK = 4;
  localparam int INT_W      = 5;
  // control structures laid out as their register bytes
  typedef struct packed {
    logic [6:0] timeout;
    logic       off;
  } hsl_wdog_cfg_t;
  typedef struct packed {
    logic       remote_block;
    logic [2:0] sda_hold;
    logic [3:0] filt_depth;
  } hsl_i2c_cfg_t;
  typedef enum logic [1:0] {ST_REQ, ST_WAIT, ST_DONE} hsl_init_st_t;
  // reset values
  localparam logic [7:0]    RST_THR_HI = 8'h01;
  localparam logic [7:0]    RST_THR_LO = 8'h00;
  localparam hsl_wdog_cfg_t RST_WDOG   = '{timeout: 7'h7f, off: 1'b0};
  localparam hsl_i2c_cfg_t  RST_I2C    = '{remote_block: 1'b0, sda_hold: 3'h1,
                                           filt_depth: 4'hc};
  localparam logic [INT_W-1:0] RST_INT_EN = 5'h00;
  // timing
  localparam int WDOG_STEP_NS  = 2000000;
  localparam int WDOG_STEP_CYC = WDOG_STEP_NS / CLK_PERIOD_NS;
  localparam int HOLD_STEP_NS  = 50;
  localparam int HOLD_STEP_CYC = HOLD_STEP_NS / CLK_PERIOD_NS;
  localparam int FILT_STEP_NS  = 5;
endpackage : hsl_pkg

// *** dv/hsl_regs_chk.sv ***
// port level assertions for the hub status and link control register bank
`timescale 1ns/1ps
module hsl_regs_chk #(
  parameter int NPORTS = 4
) (
  input wire logic              CLOCK,
  input wire logic              SRST,
  input wire logic              CYC_I,
  input wire logic              STB_I,
  input wire logic              WE_I,
  input wire logic [31:0]       DAT_O,
  input wire logic              ACK_O,
  input wire logic              IRQ,
  input wire logic              FUSE_LOAD_REQ,
  input wire logic [NPORTS-1:0] PARITY_FLAG,
  input wire logic              CC_ACTIVE,
  input wire logic              CC_ABORT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  ack_after_req_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("no ack after request");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I && !ACK_O))
    else $error("ack without request");
  rdata_upper_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
    else $error("read data upper bits set");
  abort_cause_a: assert property (CC_ABORT |-> $past(CC_ACTIVE))
    else $error("abort without transaction");
  abort_pulse_a: assert property (CC_ABORT |=> !CC_ABORT)
    else $error("abort longer than one cycle");
  flag_clear_a: assert property (|($past(PARITY_FLAG) & ~PARITY_FLAG) |-> ACK_O && !WE_I)
    else $error("parity flag fell without read");
  reload_pulse_a: assert property (FUSE_LOAD_REQ |=> !FUSE_LOAD_REQ)
    else $error("load request longer than one cycle");
  cover property (ACK_O && WE_I);
  cover property (CC_ABORT);
  cover property (|PARITY_FLAG);
  cover property (IRQ);
endmodule : hsl_regs_chk

// *** dv/test_hub_status_and_link_control_regs.sv ***
// self-checking bench for the hub status and link control register bank
`timescale 1ns/1ps
module test_hub_status_and_link_control_regs;
  logic        clock, srst, req, we, fdone, fok, refok, cc_act, rwe, scl, sda;
  logic [7:0]  idx, wd, rd, rdat;
  logic [1:0]  perr_in, pflag;
  logic [31:0] dat_o;
  logic        ack, irq, freq, abort, scl_f, sda_f;
  int          fail_count, checks_done, n;
  logic [24:0] rows [16] = '{
    {1'b0, 8'h05, 8'h00, 8'h01}, {1'b0, 8'h06, 8'h00, 8'h00}, {1'b0, 8'h07, 8'h00, 8'hfe},
    {1'b0, 8'h08, 8'h00, 8'h1c}, {1'b0, 8'h0f, 8'h00, 8'h00}, {1'b0, 8'h0e, 8'h00, 8'h00},
    {1'b0, 8'h0c, 8'h00, 8'h00}, {1'b0, 8'h03, 8'h00, 8'h00}, {1'b1, 8'h05, 8'ha5, 8'h00},
    {1'b0, 8'h05, 8'h00, 8'ha5}, {1'b1, 8'h06, 8'h5a, 8'h00}, {1'b0, 8'h06, 8'h00, 8'h5a},
    {1'b1, 8'h03, 8'hff, 8'h00}, {1'b0, 8'h03, 8'h00, 8'h00}, {1'b1, 8'h04, 8'h00, 8'h00},
    {1'b0, 8'h04, 8'h00, 8'h50}};
  hsl_regs #(.NPORTS(2), .WDOG_STEP_CYCLES(4)) dut (
    .CLOCK(clock), .SRST(srst), .ADR_I({idx, 2'b00}), .DAT_I({24'h0, wd}), .SEL_I(4'h1),
    .WE_I(we), .CYC_I(req), .STB_I(req), .DAT_O(dat_o), .ACK_O(ack), .IRQ(irq),
    .FUSE_LOAD_REQ(freq), .FUSE_LOAD_DONE(fdone), .FUSE_CKSUM_OK(fok),
    .REF_CLOCK_FREQ_OK(refok), .PARITY_ERR(perr_in), .PARITY_FLAG(pflag),
    .CC_ACTIVE(cc_act), .CC_ABORT(abort), .REMOTE_WE(rwe),
    .REMOTE_IDX(hsl_pkg::IDX_THR_HI), .REMOTE_DAT(rdat), .SCL_IN(scl), .SDA_IN(sda),
    .SCL_FILT(scl_f), .SDA_FILT(sda_f));
  always #5 clock = ~clock;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clock);
    req <= 1'b1;
    we <= w;
    idx <= i;
    wd <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = dat_o[7:0];
    req <= 1'b0;
  endtask : wb
  task automatic fuse(input logic ok);
    repeat (5) @(posedge clock);
    fok <= ok;
    fdone <= 1'b1;
    @(posedge clock);
    fdone <= 1'b0;
  endtask : fuse
  task automatic perr(input logic [1:0] p, input int k);
    repeat (k) begin
      @(posedge clock);
      perr_in <= p;
    end
    @(posedge clock);
    perr_in <= 2'b00;
    repeat (2) @(posedge clock);
  endtask : perr
  task automatic rw(input logic [7:0] d);
    @(posedge clock);
    rwe <= 1'b1;
    rdat <= d;
    @(posedge clock);
    rwe <= 1'b0;
  endtask : rw
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (8000) @(posedge clock);
    fail_count++;
    close_out();
  end
  initial begin
    {clock, req, we, fdone, fok, cc_act, rwe, idx, wd, rdat, perr_in} = '0;
    {srst, refok, scl, sda} = 4'hf;
    repeat (6) @(posedge clock);
    chk({ack, irq, pflag, abort, scl_f, sda_f}, 7'h03);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    wb(1'b0, 8'h04, 8'h00);
    chk(rd, 8'h10);
    fuse(1'b0);
    foreach (rows[k]) begin
      wb(rows[k][24], rows[k][23:16], rows[k][15:8]);
      if (!rows[k][24]) chk(rd, rows[k][7:0]);
    end
    wb(1'b1, 8'h01, 8'h04);
    repeat (2) @(posedge clock);
    chk(freq, 1'b1);
    fuse(1'b1);
    wb(1'b0, 8'h04, 8'h00);
    chk(rd, 8'hd0);
    wb(1'b1, 8'h0e, 8'h1f);
    wb(1'b1, 8'h0f, 8'h02);
    chk(irq, 1'b0);
    refok <= 1'b0;
    repeat (6) @(posedge clock);
    chk(irq, 1'b1);
    wb(1'b0, 8'h04, 8'h00);
    chk(rd, 8'hc0);
    wb(1'b1, 8'h0e, 8'h02);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    wb(1'b1, 8'h05, 8'h00);
    wb(1'b1, 8'h06, 8'h03);
    perr(2'b01, 2);
    chk(pflag, 2'b00);
    perr(2'b01, 1);
    chk(pflag, 2'b01);
    perr(2'b10, 2);
    chk(pflag, 2'b01);
    wb(1'b0, 8'h0c, 8'h00);
    chk(rd, 8'h01);
    perr(2'b11, 1);
    chk(pflag, 2'b00);
    wb(1'b1, 8'h07, 8'h04);
    n = 0;
    cc_act <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (abort !== 1'b1 && n < 40);
    chk(n >= 8 && n <= 12, 1'b1);
    cc_act <= 1'b0;
    wb(1'b1, 8'h07, 8'h05);
    cc_act <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clock);
      if (abort === 1'b1) n++;
    end
    chk(n, 0);
    cc_act <= 1'b0;
    rw(8'h33);
    wb(1'b0, 8'h05, 8'h00);
    chk(rd, 8'h33);
    wb(1'b1, 8'h08, 8'h80);
    rw(8'h44);
    wb(1'b0, 8'h05, 8'h00);
    chk(rd, 8'h33);
    wb(1'b0, 8'h0d, 8'h00);
    chk(rd, 8'h1c);
    scl <= 1'b0;
    repeat (8) @(posedge clock);
    chk(scl_f, 1'b0);
    wb(1'b1, 8'h08, 8'h0f);
    sda <= 1'b0;
    repeat (3) @(posedge clock);
    sda <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clock);
      if (sda_f !== 1'b1) n++;
    end
    chk(n, 0);
    wb(1'b1, 8'h08, 8'h70);
    sda <= 1'b0;
    repeat (20) @(posedge clock);
    chk(sda_f, 1'b1);
    repeat (30) @(posedge clock);
    chk(sda_f, 1'b0);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    chk(freq, 1'b1);
    wb(1'b0, 8'h05, 8'h00);
    chk(rd, 8'h01);
    wb(1'b0, 8'h04, 8'h00);
    chk(rd, 8'h00);
    close_out();
  end
endmodule : test_hub_status_and_link_control_regs
bind hsl_regs hsl_regs_chk #(.NPORTS(NPORTS)) chk_i (
  .CLOCK(CLOCK), .SRST(SRST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .IRQ(IRQ), .FUSE_LOAD_REQ(FUSE_LOAD_REQ), .PARITY_FLAG(PARITY_FLAG),
  .CC_ACTIVE(CC_ACTIVE), .CC_ABORT(CC_ABORT));

// *** rtl/hsl_deglitch.sv ***
// synchroniser and glitch filter for one i2c input line
`timescale 1ns/1ps
module hsl_deglitch (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       pin_in,
  input  wire logic [7:0] stable_cyc,
  output logic            level_out
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // a new level passes only after it stood for more than stable_cyc cycles
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg   <= 8'h00;
      level_out <= 1'b1;
    end else if (sync2_reg == level_out) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg >= stable_cyc) begin
      cnt_reg   <= 8'h00;
      level_out <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : hsl_deglitch

// *** rtl/hsl_regs.sv ***
// hub status and link control register bank with wishbone slave
// Operation
// - checksum-ok bit 7 set after good load
// - init-done bit 6 set after load finishes
// - bit 4 shows reference clock valid, resets 0
// - per port flag when count reaches threshold
// - threshold high byte at 0x05, reset 0x1
// - threshold low byte at 0x06, reset 0x0
// - enabled watchdog aborts overdue channel transaction
// - timeout bits 7:1 of 0x07, 2 ms steps
// - bit 0 set stops the watchdog
// - 0x08 bit 7 blocks remote register writes
// - blocking leaves remote i2c target access alone
// - sda hold is field 6:4 times 50 ns
// - glitch reject width field 3:0 times 5 ns
// - reload bit restarts load, poll init-done
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module hsl_regs #(
  parameter int NPORTS           = 4,
  parameter int WDOG_STEP_CYCLES = hsl_pkg::WDOG_STEP_CYC
) (
  input  wire logic              CLOCK,
  input  wire logic              SRST,
  input  wire logic [9:0]        ADR_I,
  input  wire logic [31:0]       DAT_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic              WE_I,
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  output logic [31:0]            DAT_O,
  output logic                   ACK_O,
  output logic                   IRQ,
  output logic                   FUSE_LOAD_REQ,
  input  wire logic              FUSE_LOAD_DONE,
  input  wire logic              FUSE_CKSUM_OK,
  input  wire logic              REF_CLOCK_FREQ_OK,
  input  wire logic [NPORTS-1:0] PARITY_ERR,
  output logic [NPORTS-1:0]      PARITY_FLAG,
  input  wire logic              CC_ACTIVE,
  output logic                   CC_ABORT,
  input  wire logic              REMOTE_WE,
  input  wire logic [7:0]        REMOTE_IDX,
  input  wire logic [7:0]        REMOTE_DAT,
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output logic                   SCL_FILT,
  output logic                   SDA_FILT
);
  if (NPORTS < 1 || NPORTS > 8) begin : g_bad_ports
    $error("NPORTS must lie between 1 and 8");
  end
  if (WDOG_STEP_CYCLES < 1) begin : g_bad_step
    $error("WDOG_STEP_CYCLES must be at least 1");
  end

  logic                   ack_reg;
  logic [7:0]             thr_hi_reg;
  logic [7:0]             thr_lo_reg;
  hsl_pkg::hsl_wdog_cfg_t wdog_reg;
  hsl_pkg::hsl_i2c_cfg_t  i2c_reg;
  logic [hsl_pkg::INT_W-1:0] int_sts_reg;
  logic [hsl_pkg::INT_W-1:0] int_en_reg;
  logic [hsl_pkg::INT_W-1:0] int_ev;
  logic                   reload_reg;
  hsl_pkg::hsl_init_st_t  st_reg;
  logic                   done_reg;
  logic                   cksum_reg;
  logic                   ref_s1_reg;
  logic                   ref_s2_reg;
  logic                   refok_reg;
  logic [31:0]            presc_reg;
  logic [6:0]             steps_reg;
  logic                   aborted_reg;
  logic [NPORTS-1:0]      flag_rise;
  logic                   acc;
  logic                   aligned;
  logic [7:0]             idx;
  logic                   wb_wr;
  logic                   wb_rd;
  logic                   rem_ok;
  logic                   lw_en;
  logic [7:0]             lw_idx;
  logic [7:0]             lw_dat;
  logic [15:0]            limit;
  logic                   par_rd_clr;
  logic [7:0]             rd_byte;
  logic                   wdog_run;
  logic [7:0]             scl_stable;
  logic [7:0]             sda_stable;

  // wishbone decode
  assign acc     = CYC_I & STB_I & ~ack_reg;
  assign aligned = (ADR_I[1:0] == 2'b00);
  assign idx     = ADR_I[9:2];
  assign wb_wr   = acc & WE_I & SEL_I[0] & aligned;
  assign wb_rd   = acc & ~WE_I & aligned;

  // remote writes reach local registers only while not blocked
  assign rem_ok = REMOTE_WE & ~i2c_reg.remote_block & ~wb_wr;
  assign lw_en  = wb_wr | rem_ok;
  assign lw_idx = wb_wr ? idx : REMOTE_IDX;
  assign lw_dat = wb_wr ? DAT_I[7:0] : REMOTE_DAT;
  // the block touches only the register path, never i2c passthrough

  assign limit      = {thr_hi_reg, thr_lo_reg};
  assign par_rd_clr = wb_rd & (idx == hsl_pkg::IDX_PAR_STS);

  // read multiplexer
  always_comb begin
    rd_byte = 8'h00;
    if (idx == hsl_pkg::IDX_RELOAD) begin
      rd_byte = 8'h00;
      rd_byte[hsl_pkg::BIT_RELOAD] = reload_reg;
    end else if (idx == hsl_pkg::IDX_STATUS) begin
      rd_byte[hsl_pkg::BIT_CKSUM] = cksum_reg;
      rd_byte[hsl_pkg::BIT_DONE]  = done_reg;
      rd_byte[hsl_pkg::BIT_REFOK] = refok_reg;
    end else if (idx == hsl_pkg::IDX_THR_HI) begin
      rd_byte = thr_hi_reg;
    end else if (idx == hsl_pkg::IDX_THR_LO) begin
      rd_byte = thr_lo_reg;
    end else if (idx == hsl_pkg::IDX_WDOG) begin
      rd_byte = wdog_reg;
    end else if (idx == hsl_pkg::IDX_I2C) begin
      rd_byte = i2c_reg;
    end else if (idx == hsl_pkg::IDX_PAR_STS) begin
      rd_byte[NPORTS-1:0] = PARITY_FLAG;
    end else if (idx == hsl_pkg::IDX_INT_STS) begin
      rd_byte[hsl_pkg::INT_W-1:0] = int_sts_reg;
    end else if (idx == hsl_pkg::IDX_INT_EN) begin
      rd_byte[hsl_pkg::INT_W-1:0] = int_en_reg;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // bus answer, one cycle after the request
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ack_reg <= 1'b0;
      DAT_O   <= 32'h0000_0000;
    end else begin
      ack_reg <= acc;
      if (acc & ~WE_I) begin
        DAT_O <= aligned ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end
  assign ACK_O = ack_reg;

  // parity threshold bytes
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      thr_hi_reg <= hsl_pkg::RST_THR_HI;
      thr_lo_reg <= hsl_pkg::RST_THR_LO;
    end else if (lw_en) begin
      if (lw_idx == hsl_pkg::IDX_THR_HI) begin
        thr_hi_reg <= lw_dat;
      end else if (lw_idx == hsl_pkg::IDX_THR_LO) begin
        thr_lo_reg <= lw_dat;
      end
    end
  end

  // watchdog and i2c control bytes
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wdog_reg <= hsl_pkg::RST_WDOG;
      i2c_reg  <= hsl_pkg::RST_I2C;
    end else if (lw_en) begin
      if (lw_idx == hsl_pkg::IDX_WDOG) begin
        wdog_reg <= lw_dat;
      end else if (lw_idx == hsl_pkg::IDX_I2C) begin
        i2c_reg <= lw_dat;
      end
    end
  end

  // interrupt enable
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      int_en_reg <= hsl_pkg::RST_INT_EN;
    end else if (lw_en && lw_idx == hsl_pkg::IDX_INT_EN) begin
      int_en_reg <= lw_dat[hsl_pkg::INT_W-1:0];
    end
  end

  // self-clearing reload request
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      reload_reg <= 1'b0;
    end else begin
      reload_reg <= lw_en & (lw_idx == hsl_pkg::IDX_RELOAD)
                    & lw_dat[hsl_pkg::BIT_RELOAD];
    end
  end

  // fuse load sequence after reset and on reload
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_reg <= hsl_pkg::ST_REQ;
    end else begin
      case (st_reg)
        hsl_pkg::ST_REQ: begin
          st_reg <= hsl_pkg::ST_WAIT;
        end
        hsl_pkg::ST_WAIT: begin
          if (FUSE_LOAD_DONE) begin
            st_reg <= hsl_pkg::ST_DONE;
          end
        end
        hsl_pkg::ST_DONE: begin
          if (reload_reg) begin
            st_reg <= hsl_pkg::ST_REQ;
          end
        end
        default: begin
          st_reg <= hsl_pkg::ST_REQ;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      FUSE_LOAD_REQ <= 1'b0;
      done_reg      <= 1'b0;
      cksum_reg     <= 1'b0;
    end else begin
      FUSE_LOAD_REQ <= (st_reg == hsl_pkg::ST_REQ);
      if (st_reg == hsl_pkg::ST_REQ) begin
        done_reg  <= 1'b0;
        cksum_reg <= 1'b0;
      end else if (st_reg == hsl_pkg::ST_WAIT && FUSE_LOAD_DONE) begin
        done_reg  <= 1'b1;
        cksum_reg <= FUSE_CKSUM_OK;
      end
    end
  end

  // reference clock detector level, three-stage synchroniser
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      refok_reg  <= 1'b0;
    end else begin
      ref_s1_reg <= REF_CLOCK_FREQ_OK;
      ref_s2_reg <= ref_s1_reg;
      refok_reg  <= ref_s2_reg;
    end
  end

  // per port saturating counters and flags
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        flag_reg;
    logic        flag_next;
    always_comb begin
      cnt_next = par_rd_clr ? 16'h0000 : cnt_reg;
      if (PARITY_ERR[p] && cnt_next != 16'hffff) begin
        cnt_next = cnt_next + 16'h0001;
      end
      flag_next = ((par_rd_clr ? 1'b0 : flag_reg)
                  | (cnt_next >= limit));
    end
    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        cnt_reg  <= 16'h0000;
        flag_reg <= 1'b0;
      end else begin
        cnt_reg  <= cnt_next;
        flag_reg <= flag_next;
      end
    end
    assign PARITY_FLAG[p] = flag_reg;
    assign flag_rise[p]   = flag_next & ~flag_reg;
  end

  // control channel watchdog
  assign wdog_run = CC_ACTIVE & ~wdog_reg.off;
  always_ff @(posedge CLOCK) begin
    if (SRST || !wdog_run) begin
      presc_reg <= 32'h0000_0000;
      steps_reg <= 7'h00;
    end else if (presc_reg == 32'(WDOG_STEP_CYCLES - 1)) begin
      presc_reg <= 32'h0000_0000;
      if (steps_reg != 7'h7f) begin
        steps_reg <= steps_reg + 7'h01;
      end
    end else begin
      presc_reg <= presc_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST || !wdog_run) begin
      CC_ABORT    <= 1'b0;
      aborted_reg <= 1'b0;
    end else begin
      CC_ABORT    <= ~aborted_reg & (steps_reg >= wdog_reg.timeout);
      aborted_reg <= aborted_reg | (steps_reg >= wdog_reg.timeout);
    end
  end

  // i2c input filtering and sda hold
  assign scl_stable = 8'((({4'h0, i2c_reg.filt_depth} * hsl_pkg::FILT_STEP_NS)
                      + hsl_pkg::CLK_PERIOD_NS - 1) / hsl_pkg::CLK_PERIOD_NS);
  assign sda_stable = scl_stable
                    + 8'({5'h00, i2c_reg.sda_hold} * hsl_pkg::HOLD_STEP_CYC);

  hsl_deglitch u_scl (
    .clock      (CLOCK),
    .srst       (SRST),
    .pin_in     (SCL_IN),
    .stable_cyc (scl_stable),
    .level_out  (SCL_FILT)
  );

  hsl_deglitch u_sda (
    .clock      (CLOCK),
    .srst       (SRST),
    .pin_in     (SDA_IN),
    .stable_cyc (sda_stable),
    .level_out  (SDA_FILT)
  );

  // interrupt status, set wins over clear
  always_comb begin
    int_ev = '0;
    int_ev[hsl_pkg::INT_INIT]   = (st_reg == hsl_pkg::ST_WAIT) & FUSE_LOAD_DONE;
    int_ev[hsl_pkg::INT_REFLOS] = refok_reg & ~ref_s2_reg;
    int_ev[hsl_pkg::INT_WDOG]   = wdog_run & ~aborted_reg
                                  & (steps_reg >= wdog_reg.timeout);
    int_ev[hsl_pkg::INT_PARITY] = |flag_rise;
    int_ev[hsl_pkg::INT_RBLOCK] = REMOTE_WE & i2c_reg.remote_block;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      int_sts_reg <= '0;
    end else if (lw_en && lw_idx == hsl_pkg::IDX_INT_CLR) begin
      int_sts_reg <= (int_sts_reg & ~lw_dat[hsl_pkg::INT_W-1:0]) | int_ev;
    end else begin
      int_sts_reg <= int_sts_reg | int_ev;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_sts_reg & int_en_reg);
    end
  end
endmodule : hsl_regs
